// file: hdl/hot_swap_fault_status_logic.v
// four-port hot-swap fault latching, retry scheduling and status mux
// assumes comparator inputs and host controls are synchronous to sys_clk_i
`timescale 1ns/1ps
`include "hot_swap_consts.vh"
module hot_swap_fault_status_logic
(
   input  wire       sys_clk_i,
   input  wire       rst_n_i,
   input  wire       osc_tick_i,          // one-cycle pulse every 6.4 ms unit
   input  wire       uvlo_i,              // supply below lockout threshold
   input  wire [3:0] port_on_i,
   input  wire [3:0] current_limit_i,
   input  wire [3:0] switch_full_on_i,    // switch drop within the full-on limit
   input  wire [3:0] low_current_i,       // current under open-circuit threshold
   input  wire       status_select_i,
   input  wire       open_detect_enable_i,
   input  wire       auto_retry_enable_i,
   input  wire [1:0] duty_select_i,
   input  wire [4:0] overload_time_i,     // units of 6.4 ms
   output reg  [3:0] gate_enable_o,
   output reg  [3:0] status_o,
   output reg  [3:0] port_open_flag_o,
   output reg        fault_n_o
);

   // operating outline, one copy per port:
   // off: switch open, waiting for the host on input
   // off with the off-time running: host requests are ignored
   // on: switch closed, overload and open timers watch the port
   // overload latch: limit outlasted the overload time
   // open latch: low current outlasted the open delay
   // either latch pulls the shared fault low while it persists
   //
   // timing:
   // all timers count oscillator ticks, not system clocks
   // a tick is a single-clock pulse, one per overload unit
   // the first tick after a timer starts may come at once
   // so the open delay and the off-time may be up to one unit short; the overload trip may be up to one unit long
   // a finer time base would cost a wider counter per port
   //
   // overload timer:
   // counts only while the port is limiting without a break
   // a clock without limit clears it; a limit clock also disarms the open detector, so the open timer cannot carry the count on
   // trip needs the count to exceed the selected units
   // the selection is clamped, so zero still gives one unit
   //
   // open detector:
   // disarmed at every turn-on and whenever power is not good
   // armed once good power has lasted the arm delay
   // the arm counter saturates to keep it from wrapping
   // open delay is a fixed count of ticks, not of overload units
   // an enable dropped mid-count restarts the open timer
   //
   // off-time:
   // starts at either latch and runs in ticks
   // its length is the retry multiplier times the overload units
   // the multiplier is read live, so a duty change takes effect at once
   // the product is sized for the largest multiplier and units
   // a host toggle clears the latch but not the off-time
   // so a port cannot be hammered back on into a short
   //
   // auto-retry:
   // only an overload latch restarts by itself
   // an open latch always waits for the host
   // retry also waits for the host on input to be high
   // with retry off the latch holds until the host drops on
   //
   // host clear:
   // a low on input is remembered while latched
   // the latch releases on the clock after that
   // so a one-clock low pulse is enough to clear
   // restart then waits for on high and the off-time to end
   //
   // status mux:
   // select high shows power good: switch on, full on, not limiting
   // select low shows the open latch, gated by the detector enable
   // both use the next state, so status moves with the gate
   // status is registered, so it trails the comparators by a clock
   //
   // fault output:
   // any latched port holds it low
   // undervoltage forces it low as well
   // it trails the port latch by one clock
   // reset, or no latched port and no undervoltage, releases it high
   //
   // undervoltage:
   // treated like reset for every port register
   // all gates open at once, no off-time survives it
   // a port whose host on input is still high powers up again after recovery
   //
   // limitations:
   // comparator inputs must already be synchronous to the clock
   // relay sequencing and analog limiting sit outside this block
   // the retry duty is approximate because of tick quantisation
   //
   // outputs:
   // every port output comes from its own register bit
   // the four port copies share only the clamp, the multiplier and their off-time product

   // clamp the overload selection into its legal range
   wire [4:0] ovl_units = (overload_time_i < `OVL_SEL_MIN) ? `OVL_SEL_MIN :
                         (overload_time_i > `OVL_SEL_MAX) ? `OVL_SEL_MAX : overload_time_i;

   // retry multiplier from the coded duty select
   reg [6:0] retry_mult;
   always @*
   begin
      case (duty_select_i)
         `DUTY_LOW:  retry_mult = `RETRY_MULT_LOW;
         `DUTY_HIGH: retry_mult = `RETRY_MULT_HIGH;
         default:    retry_mult = `RETRY_MULT_OPEN;
      endcase
   end

   // off-time in ticks; at most 99 x 20 fits in twelve bits
   wire [11:0] retry_ticks = retry_mult * {7'h00, ovl_units};

   localparam ST_OFF   = 2'h0;
   localparam ST_ON    = 2'h1;
   localparam ST_OVL   = 2'h2;
   localparam ST_OPEN  = 2'h3;

   wire [3:0] latched;

   genvar g;
   generate
      for (g = 0; g < `NUM_PORTS; g = g + 1)
      begin : port
         reg  [1:0]  state_ff;
         reg  [1:0]  nxt_state;
         reg  [11:0] cnt_ff;        // tick counter shared by the active timer
         reg  [11:0] nxt_cnt;
         reg  [7:0]  arm_ff;        // ticks of good power since turn-on
         reg  [7:0]  nxt_arm;
         reg         wait_ff;       // retry off-time still running
         reg         nxt_wait;
         reg         seen_low_ff;   // on input dropped while latched
         reg         nxt_seen_low;
         wire        good = switch_full_on_i[g] & ~current_limit_i[g];
         wire        armed = (arm_ff >= `ARM_DELAY_UNITS);

         // per-port state machine
         always @*
         begin
            nxt_state    = state_ff;
            nxt_cnt      = cnt_ff;
            nxt_arm      = arm_ff;
            nxt_wait     = wait_ff;
            nxt_seen_low = seen_low_ff;
            case (state_ff)
               ST_OFF:
               begin
                  nxt_arm = 8'h00;
                  if (wait_ff)
                  begin
                     // the off-time keeps running even if the host toggles
                     if (osc_tick_i)
                        nxt_cnt = cnt_ff + 12'h001;
                     if (cnt_ff >= retry_ticks)
                        nxt_wait = 1'b0;
                  end
                  else if (port_on_i[g])
                  begin
                     nxt_state = ST_ON;
                     nxt_cnt   = 12'h000;
                  end
               end
               ST_ON:
               begin
                  if (!port_on_i[g])
                     nxt_state = ST_OFF;
                  else if (current_limit_i[g])
                  begin
                     // limit time counted only while limiting continuously
                     if (osc_tick_i)
                        nxt_cnt = cnt_ff + 12'h001;
                     if (cnt_ff > {7'h00, ovl_units})
                     begin
                        nxt_state    = ST_OVL;
                        nxt_cnt      = 12'h000;
                        nxt_wait     = 1'b1;
                        nxt_seen_low = 1'b0;
                     end
                  end
                  else if (open_detect_enable_i && armed && low_current_i[g])
                  begin
                     if (osc_tick_i)
                        nxt_cnt = cnt_ff + 12'h001;
                     if (cnt_ff >= `OPEN_DELAY_UNITS)
                     begin
                        nxt_state    = ST_OPEN;
                        nxt_cnt      = 12'h000;
                        nxt_wait     = 1'b1;
                        nxt_seen_low = 1'b0;
                     end
                  end
                  else
                     nxt_cnt = 12'h000;
                  // arm the open detector after good power persists
                  if (!good)
                     nxt_arm = 8'h00;
                  else if (osc_tick_i && !armed)
                     nxt_arm = arm_ff + 8'h01;
               end
               default:
               begin
                  // latched: the off-time runs regardless of the host
                  if (wait_ff && osc_tick_i)
                     nxt_cnt = cnt_ff + 12'h001;
                  if (wait_ff && cnt_ff >= retry_ticks)
                     nxt_wait = 1'b0;
                  if (!port_on_i[g])
                     nxt_seen_low = 1'b1;
                  if (state_ff == ST_OVL && auto_retry_enable_i && !wait_ff && port_on_i[g])
                  begin
                     nxt_state = ST_ON;
                     nxt_cnt   = 12'h000;
                  end
                  else if (seen_low_ff)
                  begin
                     // clear the latch; off-time still gates the restart
                     nxt_state    = ST_OFF;
                     nxt_seen_low = 1'b0;
                  end
                  // otherwise the latch holds: no auto-retry
               end
            endcase
         end

         // state registers; undervoltage acts like reset
         always @(posedge sys_clk_i)
         begin
            if (!rst_n_i || uvlo_i)
            begin
               state_ff    <= ST_OFF;
               cnt_ff      <= 12'h000;
               arm_ff      <= 8'h00;
               wait_ff     <= 1'b0;
               seen_low_ff <= 1'b0;
            end
            else
            begin
               state_ff    <= nxt_state;
               cnt_ff      <= nxt_cnt;
               arm_ff      <= nxt_arm;
               wait_ff     <= nxt_wait;
               seen_low_ff <= nxt_seen_low;
            end
         end

         assign latched[g] = state_ff[1];

         // registered outputs; gate, status and open flag cleared during undervoltage
         always @(posedge sys_clk_i)
         begin
            if (!rst_n_i || uvlo_i)
            begin
               gate_enable_o[g]    <= 1'b0;
               status_o[g]         <= 1'b0;
               port_open_flag_o[g] <= 1'b0;
            end
            else
            begin
               gate_enable_o[g]    <= (nxt_state == ST_ON);
               port_open_flag_o[g] <= (nxt_state == ST_OPEN);
               if (status_select_i)
                  status_o[g] <= (nxt_state == ST_ON) & good;
               else
                  status_o[g] <= open_detect_enable_i & (nxt_state == ST_OPEN);
            end
         end
      end
   endgenerate

   // shared fault; low during undervoltage as well
   always @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         fault_n_o <= 1'b1;
      else
         fault_n_o <= ~(uvlo_i | (|latched));
   end

endmodule

// file: hdl/hot_swap_consts.vh
// constants for the four-port hot-swap fault and status logic
// assumes a 10 MHz system clock and an oscillator tick of one per 6.4 ms unit
`ifndef HOT_SWAP_CONSTS_VH
`define HOT_SWAP_CONSTS_VH
`define CLK_PERIOD_NS         100
// overload time unit, open-circuit delay and detector arm delay in microseconds
`define OVL_UNIT_US           6400
`define OPEN_DELAY_US         25600
`define ARM_DELAY_US          900000
// open delay and arm delay in overload-time units
`define OPEN_DELAY_UNITS      4
`define ARM_DELAY_UNITS       141
// overload time select range, in units of 6.4 ms (1 to 20)
`define OVL_SEL_MIN           5'h01
`define OVL_SEL_MAX           5'h14
// retry multipliers
`define RETRY_MULT_LOW        7'h63
`define RETRY_MULT_HIGH       7'h31
`define RETRY_MULT_OPEN       7'h18
// duty select encodings
`define DUTY_LOW              2'h0
`define DUTY_HIGH             2'h1
`define DUTY_OPEN             2'h2
`define NUM_PORTS             4
`endif

// file: bench/hot_swap_monitor.sv
// concurrent checks on the hot-swap fault and status block
// assumes the host and load inputs change only around sys_clk_i edges
`timescale 1ns/1ps
module hot_swap_monitor
(
   input wire       sys_clk_i, rst_n_i, osc_tick_i, uvlo_i, status_select_i,
   input wire       open_detect_enable_i, auto_retry_enable_i, fault_n_o,
   input wire [3:0] port_on_i, current_limit_i, switch_full_on_i, low_current_i,
   input wire [3:0] gate_enable_o, status_o, port_open_flag_o,
   input wire [1:0] duty_select_i,
   input wire [4:0] overload_time_i
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // lockout held over an edge leaves every switch off
   a_uvlo_gates_off: assert property (uvlo_i && $past(uvlo_i) |-> gate_enable_o == 4'h0)
      else $error("switch on in lockout");
   a_fault_on_open: assert property (|port_open_flag_o && $past(|port_open_flag_o) |-> !fault_n_o)
      else $error("open latch without fault");
   a_open_needs_low: assert property ($rose(port_open_flag_o[3]) |-> $past(low_current_i[3] && open_detect_enable_i))
      else $error("open flag without low current");
   // status mux is registered, so it follows the inputs of the previous edge
   a_pgood_status: assert property ($past(rst_n_i && !uvlo_i && status_select_i) |->
      status_o == ($past(switch_full_on_i & ~current_limit_i) & gate_enable_o))
      else $error("power-good status wrong");
   a_open_status: assert property ($past(rst_n_i && !uvlo_i && !status_select_i) |->
      status_o == (port_open_flag_o & {4{$past(open_detect_enable_i)}}))
      else $error("open status wrong");
   a_clear_on_low: assert property (1 |=> ((port_open_flag_o | gate_enable_o) & ~$past(port_on_i) & ~$past(port_on_i, 2)) == 4'h0)
      else $error("latch kept with on low");
   a_fault_release: assert property ((port_on_i == 4'h0 && !uvlo_i) [*3] |=> fault_n_o)
      else $error("fault kept after clear");
   // an overcurrent trip with the host still asking for power must not bounce back
   a_latch_holds: assert property ($fell(gate_enable_o[1]) && port_on_i[1] && $past(port_on_i[1]) && !auto_retry_enable_i
      && !uvlo_i && !$past(uvlo_i) |=> !gate_enable_o[1] [*8])
      else $error("latched port restarted");
   c_retry_trip: cover property ($fell(gate_enable_o[2]) && auto_retry_enable_i);
   c_retry_restart: cover property ($rose(gate_enable_o[2]) && auto_retry_enable_i);
   c_open_latch: cover property ($rose(port_open_flag_o[3]));
endmodule
bind hot_swap_fault_status_logic hot_swap_monitor i_hot_swap_monitor (.sys_clk_i, .rst_n_i, .osc_tick_i, .uvlo_i,
   .status_select_i, .open_detect_enable_i, .auto_retry_enable_i, .fault_n_o, .port_on_i, .current_limit_i,
   .switch_full_on_i, .low_current_i, .gate_enable_o, .status_o, .port_open_flag_o, .duty_select_i, .overload_time_i);

// file: bench/hot_swap_load_model.sv
// load and comparator model for the four switched ports
// assumes the bench chooses which ports carry a short or an open load
`timescale 1ns/1ps
module hot_swap_load_model
(
   input  wire [3:0] gate_i, short_i, open_i,
   output wire [3:0] limit_o, full_on_o, low_o
);
   // a shorted port sits in current limit and never reaches full-on
   assign limit_o   = gate_i & short_i;
   assign full_on_o = gate_i & ~short_i;
   // an off switch carries no current, so it reads as low current as well
   assign low_o     = ~gate_i | open_i;
endmodule

// file: bench/tb_hot_swap_fault_status_logic.sv
// self-checking bench for the hot-swap fault and status block
// drives host controls, a fast oscillator tick and the load model
`timescale 1ns/1ps
module tb_hot_swap_fault_status_logic;
   reg        sys_clk_i = 1'b0, rst_n_i = 1'b0, tick = 1'b0, uvlo = 1'b0, sel = 1'b0, oc_en = 1'b0, rtry = 1'b0;
   reg  [3:0] on = 4'h0, shrt = 4'h0, opn = 4'h0;
   reg  [1:0] duty = 2'h0, div = 2'h0;
   reg  [4:0] ovl = 5'h02;
   wire [3:0] gate, stat, flag, lim, full, low;
   wire       fault_n;
   int        err_total = 0, checked = 0, n;
   int        m [4] = '{99, 49, 24, 24};
   always #50 sys_clk_i = ~sys_clk_i;
   // one tick every four clocks stands in for the 6.4 ms unit to keep the run short
   always @(posedge sys_clk_i)
   begin
      div  <= div + 2'h1;
      tick <= (div == 2'h3);
   end
   // overload time two units, later zero to exercise the lower clamp
   hot_swap_fault_status_logic i_hot_swap_fault_status_logic (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .osc_tick_i(tick), .uvlo_i(uvlo), .port_on_i(on), .current_limit_i(lim), .switch_full_on_i(full),
      .low_current_i(low), .status_select_i(sel), .open_detect_enable_i(oc_en), .auto_retry_enable_i(rtry),
      .duty_select_i(duty), .overload_time_i(ovl), .gate_enable_o(gate), .status_o(stat),
      .port_open_flag_o(flag), .fault_n_o(fault_n));
   hot_swap_load_model i_hot_swap_load_model (.gate_i(gate), .short_i(shrt), .open_i(opn),
      .limit_o(lim), .full_on_o(full), .low_o(low));
   task print_verdict;
      $display("mismatches %0d, checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task cmp(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task step(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask
   // bounded wait for a gate bit (w=0) or flag bit (w=1); n holds the cycles spent
   task wt(input int w, input int p, input logic v, input int lim_c);
      n = 0;
      while (((w ? flag[p] : gate[p]) !== v) && n < lim_c)
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      if (n >= lim_c)
      begin
         err_total++;
         print_verdict();
      end
   endtask
   initial
   begin
      step(4);
      rst_n_i <= 1'b1;
      #1 cmp({3'h0, fault_n}, 4'h1);
      // all ports on, port 3 open, detectors on
      step(1);
      on <= 4'hf; opn <= 4'h8; oc_en <= 1'b1; sel <= 1'b1;
      step(4);
      #1 cmp(stat, 4'hf);
      step(480);
      #1 cmp(flag, 4'h0);
      wt(1, 3, 1'b1, 400);
      cmp(gate, 4'h7);
      step(2);
      #1 cmp({3'h0, fault_n}, 4'h0);
      sel <= 1'b0;
      step(2);
      #1 cmp(stat, 4'h8);
      oc_en <= 1'b0;
      step(2);
      #1 cmp(stat, 4'h0);
      oc_en <= 1'b1; on <= 4'h7; opn <= 4'h0; sel <= 1'b1;
      step(3);
      #1 cmp(flag, 4'h0);
      // port 1 shorted, no auto-retry: trip time, latch, host recovery
      shrt <= 4'h2;
      step(2);
      #1 cmp(stat, 4'h5);
      wt(0, 1, 1'b0, 40);
      cmp((n > 5 && n < 13) ? 4'h1 : 4'h0, 4'h1);
      step(2);
      #1 cmp(stat, 4'h5);
      cmp({3'h0, fault_n}, 4'h0);
      step(300);
      #1 cmp(gate, 4'h5);
      shrt <= 4'h0; on <= 4'h5;
      step(3);
      #1 cmp({3'h0, fault_n}, 4'h1);
      on <= 4'h7;
      step(6);
      #1 cmp(gate, 4'h5);
      wt(0, 1, 1'b1, 800);
      // off-time per duty code, fall to rise on port 2
      rtry <= 1'b1;
      // code 3 reads as open; a zero overload time clamps to one unit of four clocks
      for (int d = 0; d < 4; d++)
      begin
         duty <= d[1:0]; shrt <= 4'h4;
         if (d == 3)
            ovl <= 5'h00;
         wt(0, 2, 1'b0, 40);
         wt(0, 2, 1'b1, 1000);
         cmp((n > m[d] * ((d == 3) ? 4 : 8) - 12 && n < m[d] * ((d == 3) ? 4 : 8) + 12) ? 4'h1 : 4'h0, 4'h1);
         shrt <= 4'h0;
         step(4);
      end
      on <= 4'h0;
      step(4);
      #1 cmp({3'h0, fault_n}, 4'h1);
      uvlo <= 1'b1; on <= 4'hf;
      step(3);
      #1 cmp(gate, 4'h0);
      cmp({3'h0, fault_n}, 4'h0);
      print_verdict();
   end
endmodule
